// ---- timer16_byte_access_core.sv ----
/*
 * 16-bit timer/counter core behind an 8-bit Avalon-MM slave: counter,
 * two double-buffered compare channels, capture, flags and mask, and the
 * single shared high-byte holding register for 16-bit byte access.
 * Assumes a system clock i_mclk with synchronous inputs, and software that
 * writes high byte then low byte and reads low byte then high byte.
 */
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
// Operation
// - sixteen-bit counter, compares, capture; byte controls
// - every request has flag and mask bit
// - clock select: prescaled internal or external edge
// - no clock source selected means no ticks
// - compare registers continuously compared, drive output pins
// - compare match sets its channel flag
// - trigger edge latches counter into capture register
// - bottom means count equals 0x0000
// - maximum means count equals 0xFFFF
// - top is fixed, compare A, or capture
// - compare A as PWM top: no output A
// - compare A as PWM top stays double buffered
// - one holding register shared by all words
// - low write loads holding byte and low together
// - counter and capture low reads copy high byte into holding
// - compare reads leave holding register untouched
// - holding register survives low-byte writes
// - counter high-byte location reaches holding register
// - host counter write beats count and clear
// - capture writable only when it defines top
`include "timer16_defs.svh"

module timer16_byte_access_core #(
	parameter int PRESCALE_BITS = 10
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst,
	input  wire logic [3:0]             i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [7:0]             i_avs_writedata,
	output logic      [7:0]             o_avs_readdata,
	output logic                        o_avs_waitrequest,
	output timer16_pkg::bus_state_t     o_bus_state,
	input  wire logic                   i_ext_count_pin,
	input  wire logic                   i_capture_pin,
	input  wire logic                   i_comp_out,
	output logic                        o_compare_out_a,
	output logic                        o_compare_out_b,
	output logic      [7:0]             o_int_req
);
	import timer16_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	generate
		if (PRESCALE_BITS < 10) begin : g_bad
			$error("prescaler needs at least ten bits for the /1024 tap");
		end
	endgenerate

	bus_state_t               state_reg;
	logic [7:0]               rdata_reg;
	logic [7:0]               ctrl_a_reg;
	logic [7:0]               ctrl_b_reg;
	logic [7:0]               power_reduction_reg;
	logic [7:0]               timer_flag_reg;
	logic [7:0]               timer_mask_reg;
	logic [7:0]               irq_reg;
	logic [7:0]               hold_reg;
	logic [15:0]              count_value;
	logic [15:0]              compare_value_a;
	logic [15:0]              compare_value_b;
	logic [15:0]              cmp_act_a;
	logic [15:0]              cmp_act_b;
	logic [15:0]              capture_value;
	logic [PRESCALE_BITS-1:0] pre_reg;
	logic                     ext_prev_reg;
	logic                     out_a_reg;
	logic                     out_b_reg;
	logic [7:0]               rd_val;
	logic [15:0]              top_val;
	logic [3:0]               wgm;
	logic                     pwm_mode;
	logic                     cmpa_top;
	logic                     cap_top;
	logic                     req;
	logic                     wr_fire;
	logic                     rd_take;
	logic                     timer_tick;
	logic                     at_top;
	logic                     at_bottom;
	logic                     at_max;
	logic                     match_a;
	logic                     match_b;
	logic                     cap_hit;
	logic [7:0]               flag_set;
	logic [7:0]               flag_clr;
	clk_sel_t                 cs;

	capture_if cap_bus ();

	// ----------------------------------------------------------------
	// bus slave: one wait state, writes land on the waitrequest-low edge
	// ----------------------------------------------------------------
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & (state_reg != BUS_ACK);
	assign wr_fire           = i_avs_write & (state_reg == BUS_ACK);
	assign rd_take           = i_avs_read & (state_reg == BUS_IDLE);
	assign o_avs_readdata    = rdata_reg;
	assign o_bus_state       = state_reg;

	// handshake state
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg <= BUS_IDLE;
		end else begin
			case (state_reg)
				BUS_IDLE: state_reg <= req ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  state_reg <= BUS_IDLE;
				default:  state_reg <= BUS_IDLE;
			endcase
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		case (i_avs_address)
			`ADDR_CTRL_A:   rd_val = ctrl_a_reg;
			`ADDR_CTRL_B:   rd_val = ctrl_b_reg;
			`ADDR_COUNT_LO: rd_val = count_value[7:0];
			`ADDR_COUNT_HI: rd_val = hold_reg;
			`ADDR_CMPA_LO:  rd_val = compare_value_a[7:0];
			`ADDR_CMPA_HI:  rd_val = compare_value_a[15:8];
			`ADDR_CMPB_LO:  rd_val = compare_value_b[7:0];
			`ADDR_CMPB_HI:  rd_val = compare_value_b[15:8];
			`ADDR_CAP_LO:   rd_val = capture_value[7:0];
			`ADDR_CAP_HI:   rd_val = hold_reg;
			`ADDR_FLAG:     rd_val = timer_flag_reg;
			`ADDR_MASK:     rd_val = timer_mask_reg;
			`ADDR_POWER:    rd_val = power_reduction_reg;
			default:        rd_val = 8'h00;
		endcase
	end

	// read data is frozen at the request's first edge and stands till release
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else if (rd_take) begin
			rdata_reg <= rd_val;
		end
	end

	// ----------------------------------------------------------------
	// shared high-byte holding register
	// ----------------------------------------------------------------
	// low reads snapshot the high byte at the same edge as the low byte,
	// so the pair is atomic; compare reads never touch it
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hold_reg <= 8'h00;
		end else if (wr_fire && (i_avs_address == `ADDR_COUNT_HI ||
				i_avs_address == `ADDR_CMPA_HI || i_avs_address == `ADDR_CMPB_HI ||
				i_avs_address == `ADDR_CAP_HI)) begin
			hold_reg <= i_avs_writedata;
		end else if (rd_take && i_avs_address == `ADDR_COUNT_LO) begin
			hold_reg <= count_value[15:8];
		end else if (rd_take && i_avs_address == `ADDR_CAP_LO) begin
			hold_reg <= capture_value[15:8];
		end
		// low writes leave it alone so one high byte serves many words
		// compare low reads fall through untouched
	end

	// ----------------------------------------------------------------
	// byte control registers, mask and power
	// ----------------------------------------------------------------
	// freely written, no ordering constraint
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ctrl_a_reg          <= `CTRL_RST;
			ctrl_b_reg          <= `CTRL_RST;
			timer_mask_reg      <= `FLAG_RST;
			power_reduction_reg <= `POWER_RST;
		end else if (wr_fire) begin
			case (i_avs_address)
				`ADDR_CTRL_A: ctrl_a_reg <= i_avs_writedata;
				`ADDR_CTRL_B: ctrl_b_reg <= i_avs_writedata;
				`ADDR_MASK:   timer_mask_reg <= i_avs_writedata & `FL_USED;
				`ADDR_POWER:  power_reduction_reg <= {7'h00, i_avs_writedata[`PW_TIMER_OFF]};
				default:      ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// mode decode and top selection
	// ----------------------------------------------------------------
	assign wgm      = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
	assign cs       = clk_sel_t'(ctrl_b_reg[2:0]);
	assign pwm_mode = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hC) && (wgm != 4'hD);
	assign cmpa_top = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB) || (wgm == 4'hF);
	assign cap_top  = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC) || (wgm == 4'hE);

	// top of the sequence for the current mode
	always_comb begin
		case (wgm)
			4'h1, 4'h5: top_val = `TOP_8BIT;
			4'h2, 4'h6: top_val = `TOP_9BIT;
			4'h3, 4'h7: top_val = `TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: top_val = cmp_act_a;
			4'h8, 4'hA, 4'hC, 4'hE: top_val = capture_value;
			default:    top_val = `VAL_MAX;
		endcase
	end

	assign at_top    = (count_value == top_val);
	assign at_bottom = (count_value == `VAL_BOTTOM);
	assign at_max    = (count_value == `VAL_MAX);

	// ----------------------------------------------------------------
	// clock select and prescaler
	// ----------------------------------------------------------------
	// free-running divider; taps give /8 .. /1024
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// external pin history for edge detection
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= i_ext_count_pin;
		end
	end

	// tick source; the power-off bit, clear from reset, blocks every tick while set
	always_comb begin
		case (cs)
			CS_DIV1:     timer_tick = 1'b1;
			CS_DIV8:     timer_tick = &pre_reg[2:0];
			CS_DIV64:    timer_tick = &pre_reg[5:0];
			CS_DIV256:   timer_tick = &pre_reg[7:0];
			CS_DIV1024:  timer_tick = &pre_reg[9:0];
			CS_EXT_FALL: timer_tick = ext_prev_reg & ~i_ext_count_pin;
			CS_EXT_RISE: timer_tick = ~ext_prev_reg & i_ext_count_pin;
			default:     timer_tick = 1'b0;
		endcase
		if (power_reduction_reg[`PW_TIMER_OFF]) begin
			timer_tick = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// a host write wins over any count or clear in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			count_value <= `WORD_RST;
		end else if (wr_fire && i_avs_address == `ADDR_COUNT_LO) begin
			count_value <= {hold_reg, i_avs_writedata};
		end else if (timer_tick) begin
			count_value <= (at_top || at_max) ? `VAL_BOTTOM : count_value + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// compare channels
	// ----------------------------------------------------------------
	// host-visible buffers; low write merges the held high byte
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			compare_value_a <= `WORD_RST;
			compare_value_b <= `WORD_RST;
		end else if (wr_fire && i_avs_address == `ADDR_CMPA_LO) begin
			compare_value_a <= {hold_reg, i_avs_writedata};
		end else if (wr_fire && i_avs_address == `ADDR_CMPB_LO) begin
			compare_value_b <= {hold_reg, i_avs_writedata};
		end
	end

	// active copies: follow the buffer at once outside PWM, only at top in
	// PWM so a new period or duty never tears mid-cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmp_act_a <= `WORD_RST;
			cmp_act_b <= `WORD_RST;
		end else if (!pwm_mode || (timer_tick && at_top)) begin
			cmp_act_a <= compare_value_a;
			cmp_act_b <= compare_value_b;
		end
	end

	assign match_a = timer_tick && (count_value == cmp_act_a);
	assign match_b = timer_tick && (count_value == cmp_act_b);

	// waveform: PWM sets on wrap and clears on match, otherwise toggles on match
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			out_a_reg <= 1'b0;
		end else if (!ctrl_a_reg[`CA_OUT_EN_A] || (pwm_mode && cmpa_top)) begin
			out_a_reg <= 1'b0;
		end else if (pwm_mode && match_a) begin
			out_a_reg <= 1'b0;
		end else if (pwm_mode && timer_tick && at_top) begin
			out_a_reg <= 1'b1;
		end else if (!pwm_mode && match_a) begin
			out_a_reg <= ~out_a_reg;
		end
	end

	// channel B waveform, same scheme
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			out_b_reg <= 1'b0;
		end else if (!ctrl_a_reg[`CA_OUT_EN_B]) begin
			out_b_reg <= 1'b0;
		end else if (pwm_mode && match_b) begin
			out_b_reg <= 1'b0;
		end else if (pwm_mode && timer_tick && at_top) begin
			out_b_reg <= 1'b1;
		end else if (!pwm_mode && match_b) begin
			out_b_reg <= ~out_b_reg;
		end
	end

	assign o_compare_out_a = out_a_reg;
	assign o_compare_out_b = out_b_reg;

	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	assign cap_bus.raw      = ctrl_a_reg[`CA_CAP_SRC] ? i_comp_out : i_capture_pin;
	assign cap_bus.filt_en  = ctrl_b_reg[`CB_NC_EN];
	assign cap_bus.rise_sel = ctrl_b_reg[`CB_CAP_RISE];

	capture_cond #(
		.SAMPLES (`NC_SAMPLES)
	) u_capture_cond (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.cap    (cap_bus)
	);

	// triggers are ignored while capture defines top
	assign cap_hit = cap_bus.evt && !cap_top && !power_reduction_reg[`PW_TIMER_OFF];

	// capture latch; host may write it only when it is the top value
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			capture_value <= `WORD_RST;
		end else if (wr_fire && i_avs_address == `ADDR_CAP_LO && cap_top) begin
			capture_value <= {hold_reg, i_avs_writedata};
		end else if (cap_hit) begin
			capture_value <= count_value;
		end
	end

	// ----------------------------------------------------------------
	// flags and masked requests
	// ----------------------------------------------------------------
	always_comb begin
		flag_set               = 8'h00;
		flag_set[`FL_OVF]      = timer_tick && at_top;
		flag_set[`FL_MATCH_A]  = match_a;
		flag_set[`FL_MATCH_B]  = match_b;
		flag_set[`FL_CAPTURE]  = cap_hit;
		flag_clr               = (wr_fire && i_avs_address == `ADDR_FLAG) ?
			(i_avs_writedata & `FL_USED) : 8'h00;
	end

	// write-one-to-clear; a new event in the clearing cycle survives
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			timer_flag_reg <= `FLAG_RST;
		end else begin
			timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
		end
	end

	// each request gated by its own enable bit
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			irq_reg <= 8'h00;
		end else begin
			irq_reg <= timer_flag_reg & timer_mask_reg;
		end
	end

	assign o_int_req = irq_reg;
endmodule

// ---- timer16_defs.svh ----
/*
 * Offsets, field positions, reset values and fixed counter limits for the
 * 16-bit timer core. Included by the timer core and its capture conditioner.
 */
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the 8-bit slave)
// ----------------------------------------------------------------
`define ADDR_CTRL_A   4'h0
`define ADDR_CTRL_B   4'h1
`define ADDR_COUNT_LO 4'h2
`define ADDR_COUNT_HI 4'h3
`define ADDR_CMPA_LO  4'h4
`define ADDR_CMPA_HI  4'h5
`define ADDR_CMPB_LO  4'h6
`define ADDR_CMPB_HI  4'h7
`define ADDR_CAP_LO   4'h8
`define ADDR_CAP_HI   4'h9
`define ADDR_FLAG     4'hA
`define ADDR_MASK     4'hB
`define ADDR_POWER    4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CA_OUT_EN_A  7
`define CA_OUT_EN_B  5
`define CA_CAP_SRC   2
`define CB_NC_EN     7
`define CB_CAP_RISE  6
`define FL_OVF       0
`define FL_MATCH_A   1
`define FL_MATCH_B   2
`define FL_CAPTURE   5
`define FL_USED      8'h27
`define PW_TIMER_OFF 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST     8'h00
`define FLAG_RST     8'h00
`define POWER_RST    8'h00
`define WORD_RST     16'h0000

// ----------------------------------------------------------------
// counter limits and filter length
// ----------------------------------------------------------------
`define VAL_BOTTOM   16'h0000
`define VAL_MAX      16'hFFFF
`define TOP_8BIT     16'h00FF
`define TOP_9BIT     16'h01FF
`define TOP_10BIT    16'h03FF
`define NC_SAMPLES   4

`endif

// ---- timer16_pkg.sv ----
/*
 * Types shared by the timer core: bus handshake states and clock selects.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package timer16_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK  = 2'h2
	} bus_state_t;

	typedef enum logic [2:0] {
		CS_STOP     = 3'h0,
		CS_DIV1     = 3'h1,
		CS_DIV8     = 3'h2,
		CS_DIV64    = 3'h3,
		CS_DIV256   = 3'h4,
		CS_DIV1024  = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clk_sel_t;

endpackage

// ---- capture_if.sv ----
/*
 * Carrier between the timer core and its capture conditioner.
 * Assumes both ends run on the same system clock.
 */
interface capture_if;
	logic raw;       // selected trigger source level
	logic filt_en;   // noise filter on
	logic rise_sel;  // capture on rising edge
	logic evt;       // one-cycle capture trigger

	modport cond (input raw, input filt_en, input rise_sel, output evt);
	modport core (output raw, output filt_en, output rise_sel, input evt);
endinterface

// ---- capture_cond.sv ----
/*
 * Capture trigger conditioner: optional majority-free noise filter that
 * needs every sample equal, followed by an edge detector.
 * Assumes the trigger level is already synchronous to i_mclk.
 */
`include "timer16_defs.svh"

module capture_cond #(
	parameter int SAMPLES = `NC_SAMPLES
) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	capture_if.cond   cap
);
	import timer16_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	generate
		if (SAMPLES < 2) begin : g_bad
			$error("capture_cond needs at least two filter samples");
		end
	endgenerate

	logic [SAMPLES-1:0] hist_reg;
	logic               level_reg;
	logic               prev_reg;

	// sample history; with the filter on, the filtered level moves only when all samples agree
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hist_reg <= '0;
		end else begin
			hist_reg <= {hist_reg[SAMPLES-2:0], cap.raw};
		end
	end

	// filtered level; with the filter off the raw level passes straight on
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			level_reg <= 1'b0;
		end else if (!cap.filt_en) begin
			level_reg <= cap.raw;
		end else if (&hist_reg) begin
			level_reg <= 1'b1;
		end else if (~|hist_reg) begin
			level_reg <= 1'b0;
		end
	end

	// previous level for edge detection
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= level_reg;
		end
	end

	// toggling the edge select cannot itself fire a capture; only a level change can
	assign cap.evt = cap.rise_sel ? (level_reg & ~prev_reg) : (~level_reg & prev_reg);
endmodule

// ---- timer16_byte_access_core_chk.sv ----
/* Bus-side checker for the timer core, bound to every instance.
   Assumes the host writes a high byte before the low byte it pairs with. */
module timer16_core_chk
	import timer16_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic       i_avs_read,
	input wire logic       i_avs_write,
	input wire logic [7:0] i_avs_writedata,
	input wire logic [7:0] o_avs_readdata,
	input wire logic       o_avs_waitrequest,
	input wire bus_state_t o_bus_state,
	input wire logic [7:0] o_int_req
);
	// ----
	// shadows
	// ----
	logic        wr_done;
	logic        rd_done;
	logic        hold_ok;
	logic [7:0]  hold_sh;
	logic [7:0]  mask_sh;
	logic [15:0] cmp_a_sh;
	logic [15:0] cmp_b_sh;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// a transfer completes at the edge where waitrequest is low
	assign wr_done = i_avs_write && !o_avs_waitrequest;
	assign rd_done = i_avs_read && !o_avs_waitrequest;
	// holding byte; unknown after a counter or capture low read
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hold_sh <= 8'h00;
			hold_ok <= 1'b1;
		end else if (wr_done && i_avs_address inside {4'h3, 4'h5, 4'h7, 4'h9}) begin
			hold_sh <= i_avs_writedata;
			hold_ok <= 1'b1;
		end else if (rd_done && i_avs_address inside {4'h2, 4'h8}) begin
			hold_ok <= 1'b0;
		end
	end
	// compare words and mask as software last wrote them
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmp_a_sh <= 16'h0000;
			cmp_b_sh <= 16'h0000;
			mask_sh  <= 8'h00;
		end else if (wr_done) begin
			if (i_avs_address == 4'h4) cmp_a_sh <= {hold_sh, i_avs_writedata};
			if (i_avs_address == 4'h6) cmp_b_sh <= {hold_sh, i_avs_writedata};
			if (i_avs_address == 4'hB) mask_sh <= i_avs_writedata;
		end
	end
	AST_ONE_WAIT: assert property (
		(i_avs_read || i_avs_write) && o_bus_state == BUS_IDLE
		|=> !o_avs_waitrequest ##1 o_bus_state == BUS_IDLE) else $error("bus answer late");
	AST_HOLD_READ: assert property (
		rd_done && i_avs_address == 4'h3 && hold_ok |-> o_avs_readdata == hold_sh)
		else $error("count high read not from holding byte");
	AST_CMPA_LO: assert property (
		rd_done && i_avs_address == 4'h4 |-> o_avs_readdata == cmp_a_sh[7:0])
		else $error("compare A low wrong");
	AST_CMPA_HI: assert property (
		rd_done && i_avs_address == 4'h5 |-> o_avs_readdata == cmp_a_sh[15:8])
		else $error("compare A high wrong");
	AST_CMPB_HI: assert property (
		rd_done && i_avs_address == 4'h7 |-> o_avs_readdata == cmp_b_sh[15:8])
		else $error("compare B high wrong");
	AST_MASK_READ: assert property (
		rd_done && i_avs_address == 4'hB |-> o_avs_readdata == (mask_sh & 8'h27))
		else $error("mask readback wrong");
	AST_FLAG_SPARE: assert property (
		rd_done && i_avs_address == 4'hA |-> (o_avs_readdata & 8'hD8) == 8'h00)
		else $error("spare flag bit set");
	AST_INT_MASKED: assert property (
		(o_int_req & ~(mask_sh | $past(mask_sh))) == 8'h00) else $error("unmasked request");
endmodule

bind timer16_byte_access_core timer16_core_chk chk_inst (.i_mclk, .i_rst, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
	.o_bus_state, .o_int_req);

// ---- host_cpu_model.sv ----
/* Host CPU model: a byte-wide Avalon-MM master worked through one task.
   Assumes the bench issues one transfer at a time. */
module host_cpu_model (
	input  wire logic       i_mclk,
	input  wire logic       i_wait,
	input  wire logic [7:0] i_rdata,
	output logic      [3:0] o_addr,
	output logic            o_rd,
	output logic            o_wr,
	output logic      [7:0] o_wdata
);
	// ----
	// bus master
	// ----
	// idle bus from time zero
	initial begin
		o_addr = 4'h0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
	// one byte per transfer, held until waitrequest is low
	// no interrupt code shares the holding byte here
	// waitrequest and read data are taken at the rising edge itself, before it updates
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_mclk);
		o_addr  <= a;
		o_rd    <= !wr;
		o_wr    <= wr;
		o_wdata <= d;
		do @(posedge i_mclk); while (i_wait !== 1'b0);
		q = i_rdata;
		o_rd    <= 1'b0;
		o_wr    <= 1'b0;
		o_wdata <= ~d; // released data must not look valid
	endtask
endmodule

// ---- timer16_byte_access_core_tb.sv ----
/* Self-checking bench for the timer core driven through a host model.
   Assumes the core answers each bus request within a few cycles. */
module timer16_byte_access_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import timer16_pkg::*;
	// ----
	// bench
	// ----
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_ext_count_pin = 1'b0;
	logic        i_capture_pin = 1'b0;
	logic        i_comp_out = 1'b0;
	logic [3:0]  i_avs_address;
	logic        i_avs_read;
	logic        i_avs_write;
	logic [7:0]  i_avs_writedata;
	logic [7:0]  o_avs_readdata;
	logic        o_avs_waitrequest;
	bus_state_t  o_bus_state;
	logic        o_compare_out_a;
	logic        o_compare_out_b;
	logic [7:0]  o_int_req;
	logic [7:0]  q;
	logic [15:0] v;
	int          errors = 0;
	int          n_checks = 0;
	int          seed = 32'h22FC;
	always #20 i_mclk = ~i_mclk;
	timer16_byte_access_core timer16_byte_access_core_inst (.i_mclk, .i_rst, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
		.o_bus_state, .i_ext_count_pin, .i_capture_pin, .i_comp_out, .o_compare_out_a,
		.o_compare_out_b, .o_int_req);
	host_cpu_model host_cpu_model_inst (.i_mclk, .i_wait(o_avs_waitrequest),
		.i_rdata(o_avs_readdata), .o_addr(i_avs_address), .o_rd(i_avs_read),
		.o_wr(i_avs_write), .o_wdata(i_avs_writedata));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host_cpu_model_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		host_cpu_model_inst.xfer(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	// high byte goes first, then low
	task automatic w16(input logic [3:0] a, input logic [15:0] d);
		wr(a + 4'h1, d[15:8]);
		wr(a, d[7:0]);
	endtask
	// low byte read first, then high
	task automatic r16c(input logic [3:0] a, input logic [15:0] e);
		rc(a, e[7:0]);
		rc(a + 4'h1, e[15:8]);
	endtask
	// capture setup: rising edge, filter only on the comparator path
	function automatic logic [7:0] cap_cfg(input int s);
		return (s != 0) ? 8'hC0 : 8'h40;
	endfunction
	task automatic stop_test;
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// cut a hung handshake short
	initial begin
		repeat (20000) @(posedge i_mclk);
		errors++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		wr(4'hC, 8'h00);
		rc(4'hD, 8'h00);
		v = 16'($random(seed));
		w16(4'h2, v);
		r16c(4'h2, v);
		v = 16'($random(seed));
		wr(4'h5, v[15:8]);
		wr(4'h4, v[7:0]);
		wr(4'h6, ~v[7:0]);
		r16c(4'h4, v);
		rc(4'h7, v[15:8]);
		rc(4'h3, v[15:8]);
		w16(4'h8, 16'hA55A);
		r16c(4'h8, 16'h0000);
		wr(4'h0, 8'h02);
		wr(4'h1, 8'h18);
		w16(4'h8, 16'hA55A);
		r16c(4'h8, 16'hA55A);
		wr(4'h0, 8'h00);
		// stopped counter makes the captured value exact
		for (int s = 0; s < 2; s++) begin
			v = 16'($random(seed));
			w16(4'h2, v);
			wr(4'h0, (s != 0) ? 8'h04 : 8'h00);
			wr(4'h1, cap_cfg(s));
			if (s != 0) i_comp_out <= 1'b1;
			else i_capture_pin <= 1'b1;
			repeat (8) @(posedge i_mclk);
			rc(4'hA, 8'h20);
			r16c(4'h8, v);
			wr(4'hA, 8'h20);
			rc(4'hA, 8'h00);
		end
		// three pulses on the count pin, falling then rising edge select
		for (int e = 6; e < 8; e++) begin
			w16(4'h2, 16'h0000);
			wr(4'h1, 8'(e));
			repeat (3) begin
				i_ext_count_pin <= 1'b1;
				repeat (2) @(posedge i_mclk);
				i_ext_count_pin <= 1'b0;
				repeat (2) @(posedge i_mclk);
			end
			repeat (4) @(posedge i_mclk);
			wr(4'h1, 8'h00);
			r16c(4'h2, 16'h0003);
		end
		// run across both matches and the wrap at maximum
		wr(4'hA, 8'hFF);
		wr(4'h0, 8'hA0);
		wr(4'hB, 8'h07);
		rc(4'hB, 8'h07);
		w16(4'h4, 16'hFFF4);
		w16(4'h6, 16'hFFF8);
		w16(4'h2, 16'hFFF0);
		wr(4'h1, 8'h01);
		repeat (30) @(posedge i_mclk);
		wr(4'h1, 8'h00);
		rc(4'hA, 8'h07);
		chk(o_int_req, 8'h07);
		chk({6'h00, o_compare_out_a, o_compare_out_b}, 8'h03);
		// compare A as PWM top must force output A low although it stood high
		wr(4'h0, 8'hA3);
		wr(4'h1, 8'h19);
		repeat (2) @(posedge i_mclk);
		chk({7'h00, o_compare_out_a}, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'hA, 8'h07);
		rc(4'hA, 8'h00);
		chk(o_int_req, 8'h00);
		stop_test();
	end
endmodule
